// ==== design/pwrseq_pkg.sv ====
package pwrseq_pkg;
  // Clock rate in kHz and derived period in picoseconds
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned CLK_PS  = 50000;

  // Device self-initialization longest time (us)
  localparam int unsigned POWERUP_INIT_TIME_US = 150;
  // Longest time rounds down
  localparam int unsigned POWERUP_INIT_CYC =
    (POWERUP_INIT_TIME_US * CLK_KHZ) / 1000;

  // Host minimum times (ns, supply hold in us); the ns times rounded up to cycles
  localparam int unsigned INIT_PULSE_MIN_NS         = 200;
  localparam int unsigned INIT_RELEASE_TO_SELECT_NS = 200;
  localparam int unsigned INIT_ASSERT_TO_SELECT_NS  = 400;
  localparam int unsigned SUPPLY_LOW_HOLD_TIME_US   = 50;

  localparam int unsigned INIT_PULSE_MIN_CYC =
    (INIT_PULSE_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned INIT_RELEASE_TO_SELECT_CYC =
    (INIT_RELEASE_TO_SELECT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned INIT_ASSERT_TO_SELECT_CYC =
    (INIT_ASSERT_TO_SELECT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Host waits this long (up to device init) before first access
  localparam int unsigned POWERUP_WAIT_CYC = POWERUP_INIT_CYC;

  // Counter width
  localparam int unsigned CNT_W = 16;

  // Default configuration word restored by reset
  localparam logic [15:0] CFG_DEFAULT = 16'h8f1f;

  // Device power states
  typedef enum logic [2:0] {
    DEV_RESET, DEV_INIT, DEV_STANDBY, DEV_SLEEP, DEV_DPD
  } dev_state_type;

  // Host sequence states
  typedef enum logic [2:0] {
    HST_POWERUP, HST_PULSE, HST_RELEASE, HST_READY
  } host_state_type;
endpackage

// ==== design/pwrseq_if.sv ====
`timescale 1ns/1ps
interface pwrseq_if;
  // Active-low reset pin and active-low chip select, both host driven
  logic init_n;
  logic select_n;
  modport device_mp (input init_n, input select_n);
  modport host_mp (output init_n, output select_n);
endinterface

// ==== design/psram_powerup_reset_sequencer.sv ====
`timescale 1ns/1ps
// Behaviour
// - Self-initialization completes within 150 us
// - Host keeps select high during power-up
// - Low reset pin postpones initialization start
// - No transactions during power-up initialization
// - Initialization refreshes array, then ready
// - Host resets after short supply dip
// - Reset returns standby, restores configuration
// - Reset halts refresh, clears row counter
// - Reset exits hybrid sleep and deep power-down
// - Reset low 200 ns, 200 ns before select
// - 400 ns from reset fall to select
// - Host treats array as lost after reset
module psram_powerup_reset_sequencer
  import pwrseq_pkg::*;
#(
  parameter int unsigned INIT_CYC = pwrseq_pkg::POWERUP_INIT_CYC,
  parameter int unsigned ROW_W    = 13
) (
  // Clock and power-on reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  // Link
  pwrseq_if.device_mp                 link,
  // User side: power-mode requests and status
  input  wire logic                   sleep_req_i,
  input  wire logic                   dpd_req_i,
  input  wire logic                   wake_req_i,
  input  wire logic [15:0]            cfg_wdata_i,
  input  wire logic                   cfg_we_i,
  output logic                        ready_o,
  output logic                        refresh_active_o,
  output logic                        array_valid_o,
  output logic                        access_o,
  output logic [15:0]                 cfg_o,
  output logic [ROW_W-1:0]            refresh_row_o,
  output pwrseq_pkg::dev_state_type   state_o
);
  import pwrseq_pkg::*;

  // Power state, init counter and power-up-complete flag
  dev_state_type    state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             boot_q, boot_d;
  // Refresh row, configuration word, array and access status
  logic [ROW_W-1:0] row_q, row_d;
  logic [15:0]      cfg_q, cfg_d;
  logic             valid_q, valid_d;
  logic             access_q, access_d;
  // Conditions shared by the groups below
  logic             pin_reset;
  logic             init_last;
  logic             refreshing;

  // Reset pin level and last cycle of the init interval
  assign pin_reset  = !link.init_n;
  assign init_last  = (state_q == DEV_INIT) &&
                      (cnt_q >= CNT_W'(INIT_CYC - 1));
  // Self-refresh runs everywhere but in reset and deep power-down
  assign refreshing = (state_q == DEV_INIT) ||
                      (state_q == DEV_STANDBY) ||
                      (state_q == DEV_SLEEP);

  // Next power state: the reset pin wins over every other exit
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    boot_d  = boot_q;
    if (pin_reset) begin
      state_d = DEV_RESET;
      cnt_d   = '0;
    end else begin
      case (state_q)
        DEV_RESET: begin
          // The reset cycle counts as the first init cycle, so the
          // whole interval stays within its maximum
          if (boot_q) begin
            state_d = DEV_STANDBY;
          end else begin
            state_d = DEV_INIT;
            cnt_d   = CNT_W'(1);
          end
        end
        DEV_INIT: begin
          if (init_last) begin
            state_d = DEV_STANDBY;
            boot_d  = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        DEV_STANDBY: begin
          if (dpd_req_i) begin
            state_d = DEV_DPD;
          end else if (sleep_req_i) begin
            state_d = DEV_SLEEP;
          end
        end
        DEV_SLEEP: begin
          if (wake_req_i) begin
            state_d = DEV_STANDBY;
          end
        end
        DEV_DPD: begin
          // The array was not kept, so waking re-runs the interval
          if (wake_req_i) begin
            state_d = DEV_INIT;
            cnt_d   = '0;
          end
        end
        default: state_d = DEV_RESET;
      endcase
    end
  end

  // Power state registers; only power-on reset clears the boot flag
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= DEV_RESET;
      cnt_q   <= '0;
      boot_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      boot_q  <= boot_d;
    end
  end

  // Refresh row counter: cleared while the reset pin is low
  always_comb begin
    row_d = row_q;
    if (pin_reset) begin
      row_d = '0;
    end else if (refreshing) begin
      row_d = row_q + 1'b1;
    end
  end

  // Refresh row register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      row_q <= '0;
    end else begin
      row_q <= row_d;
    end
  end

  // Configuration word: defaults on reset, written only in standby
  always_comb begin
    cfg_d = cfg_q;
    if (pin_reset) begin
      cfg_d = CFG_DEFAULT;
    end else if (cfg_we_i && (state_q == DEV_STANDBY)) begin
      cfg_d = cfg_wdata_i;
    end
  end

  // Configuration register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_q <= CFG_DEFAULT;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Array contents: valid after an init interval, lost on reset or
  // on entry to deep power-down
  always_comb begin
    valid_d = valid_q;
    if (pin_reset) begin
      valid_d = 1'b0;
    end else if (init_last) begin
      valid_d = 1'b1;
    end else if ((state_q == DEV_STANDBY) && dpd_req_i) begin
      valid_d = 1'b0;
    end
  end

  // Array valid register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  // Access strobe: select is only honoured in standby
  always_comb begin
    access_d = 1'b0;
    if (!pin_reset && (state_q == DEV_STANDBY)) begin
      access_d = !link.select_n;
    end
  end

  // Access strobe register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      access_q <= 1'b0;
    end else begin
      access_q <= access_d;
    end
  end

  // Outputs
  assign ready_o          = (state_q == DEV_STANDBY);
  assign refresh_active_o = refreshing;
  assign array_valid_o    = valid_q;
  assign access_o         = access_q;
  assign cfg_o            = cfg_q;
  assign refresh_row_o    = row_q;
  assign state_o          = state_q;
endmodule

// ==== design/psram_host_sequencer.sv ====
`timescale 1ns/1ps
module psram_host_sequencer
  import pwrseq_pkg::*;
#(
  parameter int unsigned PWRUP_CYC = pwrseq_pkg::POWERUP_WAIT_CYC
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Link
  pwrseq_if.host_mp link,
  // User side
  input  wire logic reset_req_i,
  input  wire logic select_req_i,
  output logic      ready_o,
  output logic      reload_o
);
  import pwrseq_pkg::*;

  host_state_type   state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] fall_q, fall_d;
  logic             reload_q, reload_d;

  // Sequence: power-up wait, then ready; a reset request runs reset pulse, release gap, ready
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    fall_d   = fall_q;
    reload_d = 1'b0;
    case (state_q)
      HST_POWERUP: begin
        // Select high for full init interval, no access
        if (cnt_q >= CNT_W'(PWRUP_CYC - 1)) begin
          state_d = HST_READY;
          cnt_d   = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      HST_PULSE: begin
        cnt_d  = cnt_q + 1'b1;
        fall_d = fall_q + 1'b1;
        if (cnt_q >= CNT_W'(INIT_PULSE_MIN_CYC - 1)) begin
          state_d = HST_RELEASE;
          cnt_d   = '0;
        end
      end
      HST_RELEASE: begin
        cnt_d  = cnt_q + 1'b1;
        fall_d = fall_q + 1'b1;
        if (cnt_q >= CNT_W'(INIT_RELEASE_TO_SELECT_CYC - 1) &&
            fall_q >= CNT_W'(INIT_ASSERT_TO_SELECT_CYC - 1)) begin
          state_d  = HST_READY;
          reload_d = 1'b1;
        end
      end
      HST_READY: begin
        // Reset request also covers a short supply dip
        if (reset_req_i) begin
          state_d = HST_PULSE;
          cnt_d   = '0;
          fall_d  = '0;
        end
      end
      default: state_d = HST_POWERUP;
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q  <= HST_POWERUP;
      cnt_q    <= '0;
      fall_q   <= '0;
      reload_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      fall_q   <= fall_d;
      reload_q <= reload_d;
    end
  end

  // Pins and status
  assign link.init_n   = (state_q != HST_PULSE);
  assign link.select_n = !((state_q == HST_READY) && select_req_i);
  assign ready_o       = (state_q == HST_READY);
  assign reload_o      = reload_q;
endmodule

// ==== tb/pwrseq_sva.sv ====
`timescale 1ns/1ps
module pwrseq_sva #(
  parameter int unsigned INIT_CYC  = 20,
  parameter int unsigned PWRUP_CYC = 22
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Link and device status
  input wire logic init_n,
  input wire logic select_n,
  input wire logic ready_o,
  input wire logic array_valid_o
);
  // Device must be back in standby before the host may select
  localparam int RLS_LAT = pwrseq_pkg::INIT_RELEASE_TO_SELECT_CYC;
  logic [15:0] up_q;
  logic [15:0] up_d;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Cycles since power-on reset, saturating
  always_comb up_d = rst_i ? 16'h0 : ((&up_q) ? up_q : up_q + 16'h1);
  always_ff @(posedge sys_clk_i) up_q <= up_d;
  // Reset pulse and the quiet select window, both starting at the reset fall
  sequence pulse_low_s;
    !init_n [*4];
  endsequence
  sequence select_held_s;
    select_n [*8];
  endsequence
  chk_pulse_min: assert property (
    $fell(init_n) |-> pulse_low_s) else $error("reset pulse too short");
  chk_fall_gap: assert property (
    $fell(init_n) |-> select_held_s) else $error("select too soon");
  chk_release_gap: assert property (
    $rose(init_n) |-> select_n [*4]) else $error("select after release");
  chk_low_no_select: assert property (
    !init_n |-> select_n) else $error("select during reset");
  chk_powerup_quiet: assert property (
    up_q < PWRUP_CYC |-> select_n && init_n)
    else $error("link active in power-up");
  chk_ready_drops: assert property (
    !init_n |=> !ready_o && !array_valid_o) else $error("ready in reset");
  chk_init_time: assert property (
    up_q == INIT_CYC |-> ready_o) else $error("init too long");
  chk_init_busy: assert property (
    up_q < INIT_CYC |-> !ready_o) else $error("ready too early");
  chk_reset_ready: assert property (
    $rose(init_n) |-> ##[1:RLS_LAT] ready_o)
    else $error("no standby after reset");
endmodule

// ==== tb/psram_powerup_reset_sequencer_test.sv ====
`timescale 1ns/1ps
module psram_powerup_reset_sequencer_test;
  import pwrseq_pkg::*;
  localparam int unsigned ICYC = 20;
  localparam int unsigned PCYC = 22;
  logic          sys_clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          slp = 1'b0, dpd = 1'b0, wak = 1'b0, we = 1'b0;
  logic          rreq = 1'b0, sreq = 1'b1;
  logic [15:0]   wdata = 16'h0;
  logic          d_rdy, d_ref, d_val, d_acc, h_rdy, h_rel;
  logic [15:0]   d_cfg;
  logic [12:0]   d_row;
  dev_state_type d_st;
  int            n_mismatch = 0, checks_done = 0, cyc = 0;
  pwrseq_if link ();
  psram_powerup_reset_sequencer #(.INIT_CYC(ICYC))
  u_psram_powerup_reset_sequencer (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link),
    .sleep_req_i(slp), .dpd_req_i(dpd), .wake_req_i(wak),
    .cfg_wdata_i(wdata), .cfg_we_i(we), .ready_o(d_rdy),
    .refresh_active_o(d_ref), .array_valid_o(d_val), .access_o(d_acc),
    .cfg_o(d_cfg), .refresh_row_o(d_row), .state_o(d_st));
  psram_host_sequencer #(.PWRUP_CYC(PCYC)) u_psram_host_sequencer (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link),
    .reset_req_i(rreq), .select_req_i(sreq), .ready_o(h_rdy),
    .reload_o(h_rel));
  pwrseq_sva #(.INIT_CYC(ICYC), .PWRUP_CYC(PCYC)) u_pwrseq_sva (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .init_n(link.init_n),
    .select_n(link.select_n), .ready_o(d_rdy), .array_valid_o(d_val));
  // Clock and hang limit
  initial forever #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      conclude();
    end
  end
  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait for both ends ready (0) or the reload pulse (1), bounded
  task automatic await(input bit rel);
    int i;
    i = 0;
    while ((rel ? h_rel : (h_rdy & d_rdy)) !== 1'b1 && i < 100) begin
      @(negedge sys_clk_i);
      i++;
    end
    check({15'h0, i < 100}, 16'h1);
  endtask
  // Host reset pulse; device state checked once it has seen the pulse
  task automatic host_reset();
    rreq = 1'b1;
    @(negedge sys_clk_i);
    rreq = 1'b0;
    @(negedge sys_clk_i);
    check({15'h0, link.init_n}, 16'h0);
    check(16'(d_st), 16'(DEV_RESET));
    check(d_cfg, CFG_DEFAULT);
    check({2'h0, d_ref, d_row}, 16'h0);
    check({14'h0, d_val, d_rdy}, 16'h0);
    await(1'b1);
    await(1'b0);
    check(16'(d_st), 16'(DEV_STANDBY));
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    check({14'h0, h_rdy, d_rdy}, 16'h0);
    check({15'h0, link.select_n}, 16'h1);
    await(1'b0);
    check(16'(d_st), 16'(DEV_STANDBY));
    check({15'h0, d_ref}, 16'h1);
    check({15'h0, d_val}, 16'h1);
    check(d_cfg, CFG_DEFAULT);
    $display("test power-up done");
    sreq = 1'b0;
    wdata = 16'h1234;
    we = 1'b1;
    @(negedge sys_clk_i);
    we = 1'b0;
    @(negedge sys_clk_i);
    check(d_cfg, 16'h1234);
    host_reset();
    check(d_cfg, CFG_DEFAULT);
    sreq = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    check({15'h0, d_acc}, 16'h1);
    sreq = 1'b0;
    $display("test reset restore done");
    for (int m = 0; m < 2; m++) begin
      slp = (m == 0);
      dpd = (m == 1);
      repeat (3) @(negedge sys_clk_i);
      check(16'(d_st), m ? 16'(DEV_DPD) : 16'(DEV_SLEEP));
      slp = 1'b0;
      dpd = 1'b0;
      host_reset();
    end
    $display("test low-power exit done");
    conclude();
  end
  // Verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
endmodule
